// ---- core/iexp_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "iexp_map.vh"

// Functional notes
// R1: up to 96 peripheral request inputs, multiplexed onto fewer cpu lines.
// R2: requests grouped by eight, each group drives one of twelve cpu lines.
// R3: each request has its own software-writable vector ram entry.
// R4: winning source vector supplied automatically within 8 clock cycles.
// R5: individual enable bit for every request input.
// R6: three maskable external interrupt inputs.
// R7: third maskable and non-maskable interrupt share one pin.
// R8: per external input, falling or rising edge selectable.
// R9: per external input enable, nonmaskable included; disabled raises nothing.
// R10: 16-bit up-counter per maskable input, cleared on valid edge.
// R11: vector table writes ignored unless unlock instruction executed; lock blocks.
// R12: time-stamp counter wraps from all ones to zero.
module iexp_top #(
  parameter NGRP = 12,
  parameter GW = 8,
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire [NGRP*GW-1:0] periph_irq,
  output reg [NGRP-1:0] cpu_irq_line,
  input wire cpu_ack,
  input wire [3:0] cpu_ack_grp,
  output reg vec_valid,
  output reg vec_spurious,
  output reg [31:0] vec_data,
  input wire protect_unlock_instr,
  input wire protect_lock_instr,
  input wire ext_irq_first,
  input wire ext_irq_second,
  input wire shared_nmi_irq_pin,
  output reg cpu_nmi,
  output reg ext_irq
);

  localparam NSRC = NGRP * GW;
  localparam ST_IDLE = 2'd0;
  localparam ST_RD = 2'd1;
  localparam ST_OUT = 2'd2;
  // ****************************************************************
  // bus slave state
  // ****************************************************************
  reg dph_valid_r;
  reg dph_write_r;
  reg [11:0] dph_addr_r;
  reg unlock_r;
  reg [7:0] ext_cfg_r;
  reg [3:0] ext_stat_r;
  reg [3:0] ext_ien_r;
  reg [NSRC-1:0] pend_r;
  reg [NSRC-1:0] en_r;
  reg [1:0] st_r;
  reg [7:0] fetch_addr_r;
  reg none_r;
  reg [31:0] rd_mux;
  reg [NSRC-1:0] ack_clr;
  reg [2:0] win_bit;
  reg win_hit;
  reg [GW-1:0] grp_req;
  reg [NGRP-1:0] line_nxt;
  integer i;
  integer g;
  wire sel_acc;
  wire wr_do;
  wire vec_hit;
  wire ram_we;
  wire [31:0] ram_a_q;
  wire [31:0] ram_b_q;
  wire [3:0] ext_evt;
  wire [CW-1:0] cnt_first;
  wire [CW-1:0] cnt_second;
  wire [CW-1:0] cnt_third;
  wire [4:0] grp_idx;
  wire grp_sel_en;
  wire grp_sel_pend;
  wire [NSRC-1:0] act;
  assign sel_acc = hsel & htrans[1] & hready;
  assign wr_do = dph_valid_r & dph_write_r & hreadyout;
  assign vec_hit = (dph_addr_r[11:10] == `IEXP_VEC_BASE >> 10);
  assign ram_we = wr_do & vec_hit & unlock_r; // R11 R3
  assign grp_idx = dph_addr_r[6:2];
  assign grp_sel_en = (dph_addr_r[11:7] == (`IEXP_GRP_EN_BASE >> 7)) && (grp_idx < NGRP);
  assign grp_sel_pend = (dph_addr_r[11:7] == (`IEXP_GRP_PEND_BASE >> 7)) && (grp_idx < NGRP);
  assign act = pend_r & en_r; // R5

  // ****************************************************************
  // vector ram and external channels
  // ****************************************************************
  iexp_vec_ram #(.DW(32), .AW(8)) u_ram (
    .hclk(hclk),
    .wr_en(ram_we),
    .wr_addr(dph_addr_r[9:2]),
    .wr_data(hwdata),
    .rd_a_addr(fetch_addr_r),
    .rd_a_q(ram_a_q),
    .rd_b_addr(haddr[9:2]),
    .rd_b_q(ram_b_q)
  );
  iexp_ext_chan #(.CW(CW)) u_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_first), // R6
    .enable(ext_cfg_r[`IEXP_CFG_EN_LSB]),
    .rising_sel(ext_cfg_r[`IEXP_CFG_POL_LSB]),
    .evt_r(ext_evt[0]),
    .cnt_r(cnt_first)
  );
  iexp_ext_chan #(.CW(CW)) u_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_second), // R6
    .enable(ext_cfg_r[`IEXP_CFG_EN_LSB+1]),
    .rising_sel(ext_cfg_r[`IEXP_CFG_POL_LSB+1]),
    .evt_r(ext_evt[1]),
    .cnt_r(cnt_second)
  );
  iexp_ext_chan #(.CW(CW)) u_third (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(shared_nmi_irq_pin), // R6 R7
    .enable(ext_cfg_r[`IEXP_CFG_EN_LSB+2]),
    .rising_sel(ext_cfg_r[`IEXP_CFG_POL_LSB+2]),
    .evt_r(ext_evt[2]),
    .cnt_r(cnt_third)
  );
  // nonmaskable channel watches the same pin; its counter is unused
  iexp_ext_chan #(.CW(CW)) u_nmi (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(shared_nmi_irq_pin), // R7
    .enable(ext_cfg_r[`IEXP_CFG_EN_LSB+3]), // R9
    .rising_sel(ext_cfg_r[`IEXP_CFG_POL_LSB+3]),
    .evt_r(ext_evt[3]),
    .cnt_r()
  );

  // ****************************************************************
  // read data mux, evaluated during the read wait state
  // ****************************************************************
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (vec_hit)
      rd_mux = ram_b_q;
    else if (grp_sel_en)
      rd_mux[GW-1:0] = en_r[grp_idx*GW +: GW];
    else if (grp_sel_pend)
      rd_mux[GW-1:0] = pend_r[grp_idx*GW +: GW];
    else
    begin
      case (dph_addr_r)
        `IEXP_EXT_CFG: rd_mux[7:0] = ext_cfg_r;
        `IEXP_PROT_STAT: rd_mux[`IEXP_PROT_UNLOCK_BIT] = unlock_r;
        `IEXP_EXT_STATUS: rd_mux[3:0] = ext_stat_r;
        `IEXP_EXT_IEN: rd_mux[3:0] = ext_ien_r;
        `IEXP_EXT_CNT_FIRST: rd_mux[CW-1:0] = cnt_first;
        `IEXP_EXT_CNT_SECOND: rd_mux[CW-1:0] = cnt_second;
        `IEXP_EXT_CNT_THIRD: rd_mux[CW-1:0] = cnt_third;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // ahb-lite handshake: writes zero wait, reads one wait state
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0; // always okay
      if (sel_acc)
      begin
        dph_valid_r <= 1'b1;
        dph_write_r <= hwrite;
        dph_addr_r <= {haddr[11:2], 2'b00};
        hreadyout <= hwrite;
      end
      else if (dph_valid_r & ~hreadyout)
      begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
      end
      else if (dph_valid_r)
        dph_valid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // control registers, write protection, external status
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unlock_r <= 1'b0;
      ext_cfg_r <= `IEXP_EXT_CFG_RST;
      ext_ien_r <= `IEXP_EXT_IEN_RST;
      ext_stat_r <= 4'h0;
      ext_irq <= 1'b0;
      cpu_nmi <= 1'b0;
    end
    else
    begin
      // lock wins if both instructions arrive together
      if (protect_lock_instr)
        unlock_r <= 1'b0; // R11
      else if (protect_unlock_instr)
        unlock_r <= 1'b1; // R11
      if (wr_do && dph_addr_r == `IEXP_EXT_CFG)
        ext_cfg_r <= hwdata[7:0]; // R8 R9
      if (wr_do && dph_addr_r == `IEXP_EXT_IEN)
        ext_ien_r <= hwdata[3:0];
      // a new event wins over a clear in the same cycle
      if (wr_do && dph_addr_r == `IEXP_EXT_CLEAR)
        ext_stat_r <= (ext_stat_r & ~hwdata[3:0]) | ext_evt;
      else
        ext_stat_r <= ext_stat_r | ext_evt;
      ext_irq <= |(ext_stat_r & ext_ien_r);
      cpu_nmi <= ext_evt[3]; // R7 R9
    end
  end

  // ****************************************************************
  // peripheral pending and enable bits, group lines
  // ****************************************************************
  always @*
  begin
    line_nxt = {NGRP{1'b0}};
    for (g = 0; g < NGRP; g = g + 1)
      line_nxt[g] = |act[g*GW +: GW]; // R2
  end
  // pending bits collect requests and are cleared only by service
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= {NSRC{1'b0}};
      en_r <= {NSRC{1'b0}};
      cpu_irq_line <= {NGRP{1'b0}};
    end
    else
    begin
      // a request in the acknowledge cycle stays pending
      pend_r <= (pend_r & ~ack_clr) | periph_irq; // R1
      if (wr_do && grp_sel_en)
        en_r[grp_idx*GW +: GW] <= hwdata[GW-1:0]; // R5
      cpu_irq_line <= line_nxt; // R2
    end
  end

  // ****************************************************************
  // service: pick lowest enabled pending bit of the acknowledged group
  // ****************************************************************
  always @*
  begin
    grp_req = {GW{1'b0}};
    win_bit = 3'd0;
    win_hit = 1'b0;
    ack_clr = {NSRC{1'b0}};
    if (cpu_ack_grp < NGRP)
      grp_req = act[cpu_ack_grp*GW +: GW];
    for (i = GW - 1; i >= 0; i = i - 1)
      if (grp_req[i])
      begin
        win_bit = i[2:0];
        win_hit = 1'b1;
      end
    if (st_r == ST_IDLE && cpu_ack && win_hit)
      ack_clr[{cpu_ack_grp, win_bit}] = 1'b1;
  end
  // fetch sequence: ack, ram read, vector out (3 cycles, bound 8)
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= ST_IDLE;
      fetch_addr_r <= 8'h00;
      none_r <= 1'b0;
      vec_valid <= 1'b0;
      vec_spurious <= 1'b0;
      vec_data <= 32'h0000_0000;
    end
    else
    begin
      vec_valid <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (cpu_ack)
          begin
            fetch_addr_r <= `IEXP_PERIPH_VEC_BASE + {1'b0, cpu_ack_grp, win_bit}; // R4
            none_r <= ~win_hit;
            st_r <= ST_RD;
          end
        end
        ST_RD: st_r <= ST_OUT;
        ST_OUT:
        begin
          vec_valid <= 1'b1; // R4
          vec_spurious <= none_r;
          vec_data <= none_r ? 32'h0000_0000 : ram_a_q; // R4
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- pkg/iexp_map.vh ----
`ifndef IEXP_MAP_VH
`define IEXP_MAP_VH

// ****************************************************************
// register byte offsets (low 12 address bits)
// ****************************************************************
`define IEXP_EXT_CFG 12'h000
`define IEXP_PROT_STAT 12'h004
`define IEXP_EXT_STATUS 12'h008
`define IEXP_EXT_CLEAR 12'h00c
`define IEXP_EXT_IEN 12'h010
`define IEXP_EXT_CNT_FIRST 12'h014
`define IEXP_EXT_CNT_SECOND 12'h018
`define IEXP_EXT_CNT_THIRD 12'h01c
`define IEXP_GRP_EN_BASE 12'h100
`define IEXP_GRP_PEND_BASE 12'h180
`define IEXP_VEC_BASE 12'h400

// ****************************************************************
// field positions
// ****************************************************************
`define IEXP_CFG_EN_LSB 0
`define IEXP_CFG_POL_LSB 4
`define IEXP_PROT_UNLOCK_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define IEXP_EXT_CFG_RST 8'h00
`define IEXP_GRP_EN_RST 8'h00
`define IEXP_EXT_IEN_RST 4'h0

// ****************************************************************
// vector table layout and timing
// ****************************************************************
`define IEXP_PERIPH_VEC_BASE 8'h20
`define IEXP_VEC_FETCH_MAX 8

`endif

// ---- core/iexp_vec_ram.v ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// vector ram: one write port, two registered read ports
// ****************************************************************
module iexp_vec_ram #(
  parameter DW = 32,
  parameter AW = 8
) (
  input wire hclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_a_addr,
  output reg [DW-1:0] rd_a_q,
  input wire [AW-1:0] rd_b_addr,
  output reg [DW-1:0] rd_b_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // write and read; reads return the old word on a collision
  always @(posedge hclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_q <= mem[rd_a_addr];
    rd_b_q <= mem[rd_b_addr];
  end

endmodule
`default_nettype wire

// ---- core/iexp_ext_chan.v ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// one external interrupt input: edge select, enable, time stamp
// ****************************************************************
module iexp_ext_chan #(
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire pin,
  input wire enable,
  input wire rising_sel,
  output reg evt_r,
  output reg [CW-1:0] cnt_r
);

  reg prev_r;
  wire edge_hit;

  // falling or rising edge, as software selects
  assign edge_hit = rising_sel ? (pin & ~prev_r) : (~pin & prev_r); // R8

  // event pulse only while enabled; counter clears on any valid edge
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= 1'b0;
      evt_r <= 1'b0;
      cnt_r <= {CW{1'b0}};
    end
    else
    begin
      prev_r <= pin;
      evt_r <= enable & edge_hit; // R9
      if (edge_hit)
      begin
        cnt_r <= {CW{1'b0}}; // R10
      end
      else
      begin
        cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1}; // R10 R12
      end
    end
  end

endmodule
`default_nettype wire

// ---- test/iexp_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker for the expander top
// ****************************************************************
module iexp_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic cpu_ack,
  input wire logic vec_valid,
  input wire logic vec_spurious,
  input wire logic [31:0] vec_data,
  input wire logic cpu_nmi
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus steps: a taken read, then one wait cycle and the answer
  sequence s_rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (s_rd_taken |=> s_rd_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write inserted a wait");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside an answer");
  a_vec_latency: assert property (cpu_ack |-> ##[1:8] vec_valid)
    else $error("vector late");
  a_vec_cause: assert property ($rose(vec_valid) |-> $past(cpu_ack, 3))
    else $error("vector without service");
  a_vec_pulse: assert property (vec_valid |=> !vec_valid)
    else $error("vector valid too long");
  a_spur_zero: assert property (vec_valid && vec_spurious |-> vec_data == 32'h0)
    else $error("spurious vector not zero");
  a_nmi_pulse: assert property (cpu_nmi |=> !cpu_nmi)
    else $error("nmi not a pulse");
endmodule

bind iexp_top iexp_checker iexp_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .cpu_ack(cpu_ack), .vec_valid(vec_valid), .vec_spurious(vec_spurious),
  .vec_data(vec_data), .cpu_nmi(cpu_nmi));
`default_nettype wire

// ---- test/iexp_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// processor model: services lines and logs vectors
// ****************************************************************
module iexp_cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] cpu_irq_line,
  input wire logic vec_valid,
  input wire logic vec_spurious,
  input wire logic [31:0] vec_data,
  input wire logic auto_en,
  input wire logic [3:0] slow_cyc,
  input wire logic poke,
  input wire logic [3:0] poke_grp,
  output logic cpu_ack,
  output logic [3:0] cpu_ack_grp,
  output logic [2:0] got_cnt
);
  logic [32:0] got_q [0:3];
  logic [3:0] g;
  int n;

  // pick lowest raised line, ack it, wait for its vector
  initial
  begin
    cpu_ack = 1'b0;
    cpu_ack_grp = 4'h0;
    got_cnt = 3'h0;
    forever
    begin
      @(posedge hclk);
      if (hresetn && (poke || (auto_en && |cpu_irq_line)))
      begin
        g = 4'h0;
        for (n = 11; n >= 0; n--)
          if (cpu_irq_line[n]) g = n[3:0];
        if (poke) g = poke_grp;
        cpu_ack_grp <= g;
        repeat (slow_cyc) @(posedge hclk);
        cpu_ack <= 1'b1;
        @(posedge hclk);
        cpu_ack <= 1'b0;
        n = 0;
        while (vec_valid !== 1'b1 && n < 20)
        begin
          @(posedge hclk);
          n++;
        end
        got_q[got_cnt[1:0]] = {vec_spurious, vec_data};
        got_cnt <= got_cnt + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_interrupt_expander_ext_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iexp_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************************************
// bench top
// ****************************************************************
module tb_interrupt_expander_ext_irq;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_ack, vec_valid, vec_spurious;
  logic cpu_nmi, ext_irq, unl, lck, e1, e2, e3, auto_en, poke;
  logic [31:0] haddr, hwdata, hrdata, vec_data, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, got_cnt;
  logic [95:0] periph_irq;
  logic [11:0] cpu_irq_line;
  logic [3:0] cpu_ack_grp, poke_grp, slow_cyc;
  int err_total, n_compared, nmi_seen, i, k;

  iexp_top iexp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .periph_irq(periph_irq),
    .cpu_irq_line(cpu_irq_line), .cpu_ack(cpu_ack), .cpu_ack_grp(cpu_ack_grp),
    .vec_valid(vec_valid), .vec_spurious(vec_spurious), .vec_data(vec_data),
    .protect_unlock_instr(unl), .protect_lock_instr(lck), .ext_irq_first(e1),
    .ext_irq_second(e2), .shared_nmi_irq_pin(e3), .cpu_nmi(cpu_nmi), .ext_irq(ext_irq));
  iexp_cpu_model iexp_cpu_model_inst (.hclk(hclk), .hresetn(hresetn),
    .cpu_irq_line(cpu_irq_line), .vec_valid(vec_valid), .vec_spurious(vec_spurious),
    .vec_data(vec_data), .auto_en(auto_en), .slow_cyc(slow_cyc), .poke(poke),
    .poke_grp(poke_grp), .cpu_ack(cpu_ack), .cpu_ack_grp(cpu_ack_grp), .got_cnt(got_cnt));

  // clock and nmi pulse counter
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (cpu_nmi === 1'b1) nmi_seen++;

  // byte address of a vector entry
  function automatic [31:0] va(input int idx);
    va = `IEXP_VEC_BASE + 4 * idx;
  endfunction

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // single ahb transfer, held until hready
  task ahb_xfer(input [31:0] a, input w, input [31:0] d, output [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task ahb_wr(input [31:0] a, input [31:0] d);
    ahb_xfer(a, 1'b1, d, rd);
  endtask

  task rd_chk(input [31:0] a, input [31:0] e);
    ahb_xfer(a, 1'b0, 32'h0, rd);
    `CHK(rd, e)
  endtask

  task pulse_instr(input u);
    @(posedge hclk);
    if (u) unl <= 1'b1; else lck <= 1'b1;
    @(posedge hclk);
    unl <= 1'b0;
    lck <= 1'b0;
  endtask

  task wait_cnt(input [2:0] want);
    k = 0;
    while (got_cnt !== want && k < 300)
    begin
      @(posedge hclk);
      k++;
    end
  endtask

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #700000;
    err_total++;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    {hresetn, hsel, hwrite, unl, lck, e1, auto_en, poke} = 8'h00;
    {e2, e3} = 2'b11;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    periph_irq = 96'h0;
    poke_grp = 4'h0;
    slow_cyc = 4'h2;
    tick(3);
    hresetn <= 1'b1;
    rd_chk(`IEXP_EXT_CFG, 32'h0);
    rd_chk(`IEXP_PROT_STAT, 32'h0);
    rd_chk(`IEXP_GRP_EN_BASE + 8, 32'h0);
    rd_chk(32'h0f0, 32'h0);
    pulse_instr(1'b1);
    rd_chk(`IEXP_PROT_STAT, 32'h1);
    ahb_wr(va(51), 32'h0000_a051);
    ahb_wr(va(53), 32'h0000_a053);
    pulse_instr(1'b0);
    ahb_wr(va(51), 32'h0000_dead);
    rd_chk(va(51), 32'h0000_a051);
    // group two bits 1,3,5 and group eleven bit 7, only 3 and 5 enabled
    ahb_wr(`IEXP_GRP_EN_BASE + 8, 32'h28);
    @(posedge hclk) periph_irq <= (96'h1 << 17) | (96'h1 << 19) | (96'h1 << 21) | (96'h1 << 95);
    @(posedge hclk) periph_irq <= 96'h0;
    tick(3);
    `CHK(cpu_irq_line, 12'h004)
    rd_chk(`IEXP_GRP_PEND_BASE + 8, 32'h2a);
    rd_chk(`IEXP_GRP_PEND_BASE + 44, 32'h80);
    auto_en <= 1'b1;
    wait_cnt(3'h2);
    auto_en <= 1'b0;
    `CHK(iexp_cpu_model_inst.got_q[0], {1'b0, 32'h0000_a051})
    `CHK(iexp_cpu_model_inst.got_q[1], {1'b0, 32'h0000_a053})
    tick(3);
    `CHK(cpu_irq_line, 12'h000)
    rd_chk(`IEXP_GRP_PEND_BASE + 8, 32'h02);
    // out-of-range group, then a group with nothing enabled pending
    slow_cyc <= 4'h0;
    for (i = 0; i < 2; i++)
    begin
      @(posedge hclk);
      poke <= 1'b1;
      poke_grp <= (i == 0) ? 4'hc : 4'h2;
      @(posedge hclk) poke <= 1'b0;
      wait_cnt(3'(3 + i));
      `CHK(iexp_cpu_model_inst.got_q[2 + i], 33'h1_0000_0000)
    end
    // first rising, others falling, all enabled
    ahb_wr(`IEXP_EXT_IEN, 32'h7);
    ahb_wr(`IEXP_EXT_CFG, 32'h1f);
    @(posedge hclk) {e1, e2, e3} <= 3'b100;
    tick(4);
    `CHK(nmi_seen, 1)
    `CHK(ext_irq, 1'b1)
    rd_chk(`IEXP_EXT_STATUS, 32'hf);
    ahb_xfer(`IEXP_EXT_CNT_FIRST, 1'b0, 32'h0, rd);
    `CHK(rd < 32'd40, 1'b1)
    // two back-to-back reads capture the counter four edges apart
    k = rd;
    ahb_xfer(`IEXP_EXT_CNT_FIRST, 1'b0, 32'h0, rd);
    `CHK(rd - k, 4)
    ahb_xfer(`IEXP_EXT_CNT_THIRD, 1'b0, 32'h0, rd);
    `CHK(rd < 32'd40, 1'b1)
    ahb_wr(`IEXP_EXT_CLEAR, 32'hf);
    tick(3);
    `CHK(ext_irq, 1'b0)
    // wrong edge on first, disabled second and nmi
    ahb_wr(`IEXP_EXT_CFG, 32'h11);
    @(posedge hclk) {e1, e2, e3} <= 3'b011;
    tick(2);
    {e2, e3} <= 2'b00;
    tick(4);
    rd_chk(`IEXP_EXT_STATUS, 32'h0);
    `CHK(nmi_seen, 1)
    e1 <= 1'b1;
    tick(4);
    rd_chk(`IEXP_EXT_STATUS, 32'h1);
    // reads 65536 edges apart see the same value only if the counter wraps
    ahb_xfer(`IEXP_EXT_CNT_SECOND, 1'b0, 32'h0, rd);
    k = rd;
    tick(65532);
    ahb_xfer(`IEXP_EXT_CNT_SECOND, 1'b0, 32'h0, rd);
    `CHK(rd, k)
    report_and_stop;
  end
endmodule
`default_nettype wire
